//--- verilog/usr_snooze_rx.sv
// Purpose: Serial receiver that can take a frame during snooze
// Assumes: Clock is the fast on-chip oscillator, 250 MHz; STOP_REQ from
//          the power controller on the same clock
// Notes:   8 data bits, optional even parity, one stop bit
//
// The strobed register port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module usr_snooze_rx #(
  parameter int FIFO_DEPTH = usr_pkg::FIFO_DEPTH
) (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic [usr_pkg::ADDR_W-1:0] ADDR,
  input wire logic [usr_pkg::DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [usr_pkg::DATA_W-1:0] RDATA,
  input wire logic STOP_REQ,
  input wire logic SERIAL_RECEIVE_PIN,
  output logic SNOOZE,
  output logic RECEIVE_COMPLETE_INTERRUPT,
  output logic RECEIVE_ERROR_INTERRUPT
);
  import usr_pkg::*;
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic rx_meta_reg;                // First synchroniser stage
  logic rx_sync_reg;                // Second stage, safe to read
  logic rx_prev_reg;                // For edge detection
  logic [CTL_W-1:0] ctrl_reg;       // Software control bits
  logic [15:0] baud_reg;            // Clocks per bit minus one
  logic pe_reg, fe_reg, ovr_reg;    // Sticky error flags
  usr_pwr_t pwr_reg, pwr_next;      // Power view of the channel
  usr_rx_t rx_reg;                  // Frame receiver state
  logic [15:0] cnt_reg;             // Bit timer
  logic [2:0] bit_reg;              // Data bit index
  logic [7:0] shift_reg;            // Incoming byte
  logic par_reg;                    // Running parity
  logic pe_pend_reg;                // Parity fault of this frame
  logic fall;
  logic allowed;
  logic tick;
  logic frame_end;
  logic frame_fe;
  logic frame_err;
  logic quiet;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [7:0] fifo_out_data;
  logic pop;
  logic wake;
  logic sup;

  assign wake = ctrl_reg[CTL_WAKE];
  assign sup = ctrl_reg[CTL_SUPPRESS];
  assign fall = rx_prev_reg && !rx_sync_reg;
  // Stop without wake closes the receiver; snooze keeps it running
  assign allowed = (pwr_reg == PWR_RUN) ? ctrl_reg[CTL_RX_EN] : wake;
  assign tick = (cnt_reg == 16'h0000);
  assign frame_end = allowed && (rx_reg == RX_STOPB) && tick;
  assign frame_fe = !rx_sync_reg;
  assign frame_err = frame_end && (frame_fe || pe_pend_reg || !fifo_in_ready);
  assign quiet = sup;
  assign pop = RD && (ADDR == OFS_DATA);

  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------
  // Line idles high, so reset to the idle level
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      rx_meta_reg <= 1'b1;
      rx_sync_reg <= 1'b1;
      rx_prev_reg <= 1'b1;
    end else begin
      rx_meta_reg <= SERIAL_RECEIVE_PIN;
      rx_sync_reg <= rx_meta_reg;
      rx_prev_reg <= rx_sync_reg;
    end
  end

  // ----------------------------------------------------------------
  // Power state
  // ----------------------------------------------------------------
  // Snooze lasts until the power controller drops STOP_REQ
  always_comb begin
    pwr_next = pwr_reg;
    if (!STOP_REQ) begin
      pwr_next = PWR_RUN;
    end else if (pwr_reg == PWR_RUN) begin
      pwr_next = PWR_STOP;
    end else if (pwr_reg == PWR_STOP && wake && fall) begin
      pwr_next = PWR_SNOOZE;
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      pwr_reg <= PWR_RUN;
      SNOOZE <= 1'b0;
    end else begin
      pwr_reg <= pwr_next;
      SNOOZE <= (pwr_next == PWR_SNOOZE);
    end
  end

  // ----------------------------------------------------------------
  // Frame receiver
  // ----------------------------------------------------------------
  // Start is re-checked at mid bit so glitches do not start a frame
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      rx_reg <= RX_IDLE;
      cnt_reg <= 16'h0000;
      bit_reg <= 3'h0;
      shift_reg <= 8'h00;
      par_reg <= 1'b0;
      pe_pend_reg <= 1'b0;
    end else if (!allowed) begin
      rx_reg <= RX_IDLE;
    end else begin
      cnt_reg <= tick ? 16'h0000 : cnt_reg - 16'h0001;
      case (rx_reg)
        RX_IDLE: begin
          if (fall) begin
            rx_reg <= RX_START;
            cnt_reg <= {1'b0, baud_reg[15:1]};
          end
        end
        RX_START: begin
          if (tick) begin
            if (rx_sync_reg) begin
              rx_reg <= RX_IDLE;
            end else begin
              rx_reg <= RX_DATA;
              cnt_reg <= baud_reg;
              bit_reg <= 3'h0;
              par_reg <= 1'b0;
              pe_pend_reg <= 1'b0;
            end
          end
        end
        RX_DATA: begin
          if (tick) begin
            shift_reg <= {rx_sync_reg, shift_reg[7:1]};
            par_reg <= par_reg ^ rx_sync_reg;
            bit_reg <= bit_reg + 3'h1;
            cnt_reg <= baud_reg;
            if (bit_reg == 3'(FRAME_BITS - 1)) begin
              rx_reg <= ctrl_reg[CTL_PARITY] ? RX_PAR : RX_STOPB;
            end
          end
        end
        RX_PAR: begin
          if (tick) begin
            pe_pend_reg <= par_reg ^ rx_sync_reg;
            cnt_reg <= baud_reg;
            rx_reg <= RX_STOPB;
          end
        end
        RX_STOPB: begin
          if (tick) begin
            rx_reg <= RX_IDLE;
          end
        end
        default: begin
          rx_reg <= RX_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Receive buffer
  // ----------------------------------------------------------------
  // A full buffer refuses the byte, which shows as overrun
  usr_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(CLOCK),
    .rst(RST),
    .in_data(shift_reg),
    .in_valid(frame_end),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out_data),
    .out_valid(fifo_out_valid),
    .out_ready(pop)
  );

  // ----------------------------------------------------------------
  // Interrupt pulses
  // ----------------------------------------------------------------
  // Complete fires on every stored byte, which also wakes the core
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      RECEIVE_COMPLETE_INTERRUPT <= 1'b0;
      RECEIVE_ERROR_INTERRUPT <= 1'b0;
    end else begin
      RECEIVE_COMPLETE_INTERRUPT <= frame_end && fifo_in_ready;
      RECEIVE_ERROR_INTERRUPT <= frame_err && !quiet && ctrl_reg[CTL_ERR_IRQ];
    end
  end

  // ----------------------------------------------------------------
  // Error flags
  // ----------------------------------------------------------------
  // A new error in the clearing cycle wins over the clear
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      pe_reg <= 1'b0;
      fe_reg <= 1'b0;
      ovr_reg <= 1'b0;
    end else begin
      pe_reg <= (pe_reg && !(WR && ADDR == OFS_STATUS && WDATA[ST_PE]))
                || (frame_end && pe_pend_reg && !quiet);
      fe_reg <= (fe_reg && !(WR && ADDR == OFS_STATUS && WDATA[ST_FE]))
                || (frame_end && frame_fe && !quiet);
      ovr_reg <= (ovr_reg && !(WR && ADDR == OFS_STATUS && WDATA[ST_OVR]))
                 || (frame_end && !fifo_in_ready && !quiet);
    end
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      ctrl_reg <= CTRL_RST;
      baud_reg <= BAUD_RST;
    end else if (WR) begin
      if (ADDR == OFS_CTRL) begin
        ctrl_reg <= WDATA[CTL_W-1:0];
      end else if (ADDR == OFS_BAUD) begin
        baud_reg <= WDATA[15:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  // Data stand for one cycle only; unmapped reads give zero
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      RDATA <= '0;
    end else if (!RD) begin
      RDATA <= '0;
    end else if (ADDR == OFS_CTRL) begin
      RDATA <= {27'h0000000, ctrl_reg};
    end else if (ADDR == OFS_STATUS) begin
      RDATA <= {26'h0000000, fifo_out_valid, (pwr_reg == PWR_SNOOZE),
                (rx_reg != RX_IDLE), ovr_reg, fe_reg, pe_reg};
    end else if (ADDR == OFS_DATA) begin
      RDATA <= fifo_out_valid ? {24'h000000, fifo_out_data} : '0;
    end else if (ADDR == OFS_BAUD) begin
      RDATA <= {16'h0000, baud_reg};
    end else begin
      RDATA <= '0;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  sequence wake_edge_s;
    pwr_reg == PWR_STOP && STOP_REQ && wake && fall;
  endsequence
  sequence one_pulse_s;
    RECEIVE_COMPLETE_INTERRUPT ##1 !RECEIVE_COMPLETE_INTERRUPT;
  endsequence

  snooze_entry_a: assert property (wake_edge_s |=> pwr_reg == PWR_SNOOZE && SNOOZE)
    else $error("stop did not enter snooze on edge");
  snooze_rx_a: assert property (wake_edge_s |=> rx_reg == RX_START)
    else $error("snooze edge did not start reception");
  stop_halt_a: assert property (pwr_reg == PWR_STOP && !wake |=> rx_reg == RX_IDLE)
    else $error("receiver ran in stop without wake");
  err_quiet_a: assert property (frame_err && sup |=> !RECEIVE_ERROR_INTERRUPT
      && !$rose(pe_reg) && !$rose(fe_reg) && !$rose(ovr_reg))
    else $error("error reported while suppressed");
  short_start_a: assert property (allowed && rx_reg == RX_START && tick && rx_sync_reg
      |=> rx_reg == RX_IDLE ##1 !RECEIVE_COMPLETE_INTERRUPT)
    else $error("short pulse began a frame");
  wake_irq_a: assert property (pwr_reg == PWR_SNOOZE && frame_end && fifo_in_ready
      |=> one_pulse_s)
    else $error("snooze frame gave no complete pulse");
  rd_timing_a: assert property (RD && ADDR == OFS_CTRL |=> RDATA == {27'h0000000, $past(ctrl_reg)}
      ##1 ($past(RD) || RDATA == '0))
    else $error("read data not in following cycle only");
endmodule : usr_snooze_rx
`default_nettype wire

//--- verilog/usr_pkg.sv
// Purpose: Shared constants for the snooze-capable serial receiver
// Assumes: 32-bit register port, byte-wide frames, one clock
// Notes:   Offsets are byte addresses on the plain register port
package usr_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;                  // Register address width
  localparam int DATA_W = 32;                 // Register data width
  localparam logic [7:0] OFS_CTRL = 8'h00;    // Control bits
  localparam logic [7:0] OFS_STATUS = 8'h04;  // Status, error flags write-1-to-clear
  localparam logic [7:0] OFS_DATA = 8'h08;    // Received byte, read pops
  localparam logic [7:0] OFS_BAUD = 8'h0C;    // Clocks per bit minus one
  // ----------------------------------------------------------------
  // Control field positions
  // ----------------------------------------------------------------
  localparam int CTL_RX_EN = 0;       // Receiver enable in run state
  localparam int CTL_WAKE = 1;        // snooze_wake_enable
  localparam int CTL_SUPPRESS = 2;    // snooze_error_suppress
  localparam int CTL_ERR_IRQ = 3;     // error_interrupt_mask_ctrl
  localparam int CTL_PARITY = 4;      // Even parity bit expected
  localparam int CTL_W = 5;
  // ----------------------------------------------------------------
  // Status field positions
  // ----------------------------------------------------------------
  localparam int ST_PE = 0;           // parity_error_flag
  localparam int ST_FE = 1;           // framing_error_flag
  localparam int ST_OVR = 2;          // overrun_error_flag
  localparam int ST_ACTIVE = 3;       // transfer_active_flag
  localparam int ST_SNOOZE = 4;       // Snooze state
  localparam int ST_AVAIL = 5;        // Byte waiting
  // ----------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------
  localparam logic [CTL_W-1:0] CTRL_RST = 5'h00;
  localparam logic [15:0] BAUD_RST = 16'h00D9;  // Clocks per bit minus one after reset
  localparam int FRAME_BITS = 8;                // Data bits per frame
  localparam int FIFO_DEPTH = 16;               // Receive buffer words
  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {PWR_RUN, PWR_STOP, PWR_SNOOZE} usr_pwr_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOPB} usr_rx_t;
endpackage : usr_pkg

//--- verilog/usr_fifo.sv
// Purpose: Receive byte buffer with valid/ready on both sides
// Assumes: Single clock, asynchronous active-high reset
// Notes:   Full shows as in_ready low; empty as out_valid low
`timescale 1ns/1ps
`default_nettype none
module usr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  // ----------------------------------------------------------------
  // Storage and pointers
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] mem [DEPTH];   // Byte store
  logic [AW-1:0] wr_ptr_reg;       // Next slot to fill
  logic [AW-1:0] rd_ptr_reg;       // Oldest slot
  logic [AW:0] count_reg;          // Words held
  logic push;
  logic pop;

  assign in_ready = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data = mem[rd_ptr_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Store side, no reset needed for data
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  // Pointer and fill count
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : usr_fifo
`default_nettype wire

//--- verification/usr_tx_model.sv
// Purpose: Remote serial transmitter that drives the receive line
// Assumes: Same clock as the bench, fixed bit length in clocks
// Notes:   Line idles high; tasks are entered just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module usr_tx_model #(
  parameter int BIT_CLKS = 8  // Clocks per bit, matches the rate register plus one
) (
  input wire logic clk,
  output logic line
);
  // ----------------------------------------------------------------
  // Frame sender
  // ----------------------------------------------------------------
  initial line = 1'b1;  // Idle high before the first frame

  // Whole frame, LSB first; a low stop level makes a framing fault on purpose
  task automatic send(input logic [7:0] data, input logic stop_lvl);
    int i;
    line <= 1'b0;  // Start bit
    repeat (BIT_CLKS) @(posedge clk);
    for (i = 0; i < 8; i++) begin
      line <= data[i];
      repeat (BIT_CLKS) @(posedge clk);
    end
    line <= stop_lvl;  // Stop bit
    repeat (BIT_CLKS) @(posedge clk);
    line <= 1'b1;  // Back to idle, gap before the next frame
    repeat (2 * BIT_CLKS) @(posedge clk);
  endtask : send

  // Frame with a parity bit before a high stop bit
  task automatic send_par(input logic [7:0] data, input logic par_lvl);
    int i;
    line <= 1'b0;  // Start bit
    repeat (BIT_CLKS) @(posedge clk);
    for (i = 0; i < 8; i++) begin
      line <= data[i];
      repeat (BIT_CLKS) @(posedge clk);
    end
    line <= par_lvl;  // Parity bit
    repeat (BIT_CLKS) @(posedge clk);
    line <= 1'b1;  // Stop bit, then the idle gap
    repeat (3 * BIT_CLKS) @(posedge clk);
  endtask : send_par

  // Pulse far shorter than half a bit, too short to be a start bit
  task automatic glitch();
    line <= 1'b0;
    repeat (2) @(posedge clk);
    line <= 1'b1;
    repeat (4 * BIT_CLKS) @(posedge clk);
  endtask : glitch
endmodule : usr_tx_model
`default_nettype wire

//--- verification/test_usr_snooze_rx.sv
// Purpose: Self-checking bench for the snooze-capable serial receiver
// Assumes: One 250 MHz clock, which stands for the fast on-chip oscillator
// Notes:   Reads queue their expectations; a monitor compares the answers
`timescale 1ns/1ps
`default_nettype none
module test_usr_snooze_rx;
  import usr_pkg::*;
  `define CHK(nm, e, g) begin compares++; if ((e) !== (g)) begin n_fail++; \
    $display("[ERR] %s expected %h seen %h", nm, e, g); end end
  // ----------------------------------------------------------------
  // Signals and bookkeeping
  // ----------------------------------------------------------------
  logic CLOCK = 1'b0;
  logic RST = 1'b1;
  logic [ADDR_W-1:0] ADDR = '0;
  logic [DATA_W-1:0] WDATA = '0;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic STOP_REQ = 1'b0;
  logic [DATA_W-1:0] RDATA;
  logic SERIAL_RECEIVE_PIN;
  logic SNOOZE, RECEIVE_COMPLETE_INTERRUPT, RECEIVE_ERROR_INTERRUPT;
  int n_fail = 0;
  int compares = 0;
  int n_cmp = 0;  // Complete pulses seen
  int n_err = 0;  // Error pulses seen
  int e_cmp = 0;  // Complete pulses expected
  int e_err = 0;  // Error pulses expected
  logic rd_pend = 1'b0;
  logic [DATA_W-1:0] q_exp[$];  // Expected read data
  logic [DATA_W-1:0] q_msk[$];  // Bits that matter
  logic [31:0] lfsr_reg = 32'h12bd;
  logic [7:0] b;
  logic [7:0] fill[16];

  // Clock: 4 ns period
  initial forever #2 CLOCK = ~CLOCK;

  // ----------------------------------------------------------------
  // Design and far-side transmitter
  // ----------------------------------------------------------------
  usr_snooze_rx #(.FIFO_DEPTH(FIFO_DEPTH)) dut (.CLOCK(CLOCK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .STOP_REQ(STOP_REQ), .SERIAL_RECEIVE_PIN(SERIAL_RECEIVE_PIN),
    .SNOOZE(SNOOZE), .RECEIVE_COMPLETE_INTERRUPT(RECEIVE_COMPLETE_INTERRUPT),
    .RECEIVE_ERROR_INTERRUPT(RECEIVE_ERROR_INTERRUPT));
  usr_tx_model #(.BIT_CLKS(8)) tx (.clk(CLOCK), .line(SERIAL_RECEIVE_PIN));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Galois LFSR, one step per byte
  function automatic logic [7:0] next_rand();
    lfsr_reg = {1'b0, lfsr_reg[31:1]} ^ (lfsr_reg[0] ? 32'h80200003 : 32'h0);
    return lfsr_reg[7:0];
  endfunction : next_rand

  // One-cycle write
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLOCK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLOCK);
    WR <= 1'b0;
  endtask : wr

  // One-cycle read; the monitor checks the answer in the next cycle
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    @(posedge CLOCK);
    ADDR <= a;
    RD <= 1'b1;
    q_exp.push_back(e);
    q_msk.push_back(m);
    @(posedge CLOCK);
    RD <= 1'b0;
  endtask : rd

  task automatic idle(input int n);
    repeat (n) @(posedge CLOCK);
  endtask : idle

  // ----------------------------------------------------------------
  // Monitor: read answers and interrupt pulses
  // ----------------------------------------------------------------
  always @(posedge CLOCK) begin
    if (rd_pend && q_exp.size() > 0) begin
      `CHK("read data", q_exp[0] & q_msk[0], RDATA & q_msk[0])
      void'(q_exp.pop_front());
      void'(q_msk.pop_front());
    end
    rd_pend <= RD;
    if (RECEIVE_COMPLETE_INTERRUPT === 1'b1) n_cmp++;
    if (RECEIVE_ERROR_INTERRUPT === 1'b1) n_err++;
  end

  // Verdict and end of run
  task automatic complete_run();
    $display("Counts: %0d compares, %0d mismatches", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run

  // Watchdog: twenty-four frames of about a hundred clocks fit well inside
  initial begin
    repeat (20000) @(posedge CLOCK);
    n_fail++;
    $display("[ERR] watchdog expected done seen hang");
    complete_run();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge CLOCK);
    RST <= 1'b0;
    // Reset values and an unmapped address
    rd(OFS_CTRL, 32'h0, 32'hFFFFFFFF);
    rd(OFS_BAUD, 32'h00D9, 32'hFFFFFFFF);
    rd(8'h10, 32'h0, 32'hFFFFFFFF);
    $display("test registers done");
    // Short bit time; the single clock stands for the fast oscillator
    wr(OFS_BAUD, 32'h7);
    wr(OFS_CTRL, 32'h9);
    // Run-state frame
    b = next_rand();
    tx.send(b, 1'b1);
    e_cmp++;
    `CHK("complete count", e_cmp, n_cmp)
    rd(OFS_DATA, {24'h0, b}, 32'hFF);
    // Framing fault without suppression raises flag and error pulse
    b = next_rand();
    tx.send(b, 1'b0);
    e_cmp++;
    e_err++;
    `CHK("error count", e_err, n_err)
    rd(OFS_STATUS, 32'h2, 32'h7);
    wr(OFS_STATUS, 32'h7);
    rd(OFS_DATA, {24'h0, b}, 32'hFF);
    $display("test run frames done");
    // Even parity: a good frame, then a wrong parity bit
    wr(OFS_CTRL, 32'h19);
    b = next_rand();
    tx.send_par(b, ^b);
    e_cmp++;
    `CHK("complete count", e_cmp, n_cmp)
    rd(OFS_DATA, {24'h0, b}, 32'hFF);
    b = next_rand();
    tx.send_par(b, ~^b);
    e_cmp++;
    e_err++;
    `CHK("error count", e_err, n_err)
    rd(OFS_STATUS, 32'h1, 32'h7);
    wr(OFS_STATUS, 32'h7);
    rd(OFS_DATA, {24'h0, b}, 32'hFF);
    $display("test parity done");
    // Stop without wake: frame lost, no snooze
    STOP_REQ <= 1'b1;
    tx.send(next_rand(), 1'b1);
    `CHK("complete count", e_cmp, n_cmp)
    `CHK("snooze", 1'b0, SNOOZE)
    STOP_REQ <= 1'b0;
    idle(4);
    $display("test stop halt done");
    // Flags cleared and buffer read before wake is set
    wr(OFS_CTRL, 32'hA);
    STOP_REQ <= 1'b1;
    idle(3);
    b = next_rand();
    tx.send(b, 1'b1);
    e_cmp++;
    `CHK("snooze", 1'b1, SNOOZE)
    `CHK("complete count", e_cmp, n_cmp)
    rd(OFS_DATA, {24'h0, b}, 32'hFF);
    rd(OFS_STATUS, 32'h10, 32'h18);
    // Too-short pulse: no transfer, snooze kept
    tx.glitch();
    `CHK("complete count", e_cmp, n_cmp)
    `CHK("snooze", 1'b1, SNOOZE)
    // Suppressed framing fault in snooze: no flag, no error pulse
    wr(OFS_CTRL, 32'hE);
    b = next_rand();
    tx.send(b, 1'b0);
    e_cmp++;
    `CHK("error count", e_err, n_err)
    rd(OFS_STATUS, 32'h0, 32'h7);
    rd(OFS_DATA, {24'h0, b}, 32'hFF);
    STOP_REQ <= 1'b0;
    idle(3);
    `CHK("snooze", 1'b0, SNOOZE)
    $display("test snooze done");
    // Fill the buffer while software stalls, then one more to overrun
    wr(OFS_CTRL, 32'h1);
    for (int i = 0; i < 16; i++) begin
      fill[i] = next_rand();
      tx.send(fill[i], 1'b1);
    end
    tx.send(next_rand(), 1'b1);
    e_cmp += 16;
    `CHK("complete count", e_cmp, n_cmp)
    rd(OFS_STATUS, 32'h24, 32'h24);
    for (int i = 0; i < 16; i++) rd(OFS_DATA, {24'h0, fill[i]}, 32'hFF);
    rd(OFS_DATA, 32'h0, 32'hFFFFFFFF);
    rd(OFS_STATUS, 32'h0, 32'h20);
    idle(4);
    $display("test buffer done");
    complete_run();
  end
endmodule : test_usr_snooze_rx
`default_nettype wire
